// *** verilog/modem_status_pkg.sv ***
/*
 * Shared constants for the modem status and reset block of one serial
 * channel: register offsets, field positions, reset values, state codes.
 * Assumes a 32-bit Avalon-MM slave with word-aligned registers.
 */
package modem_status_pkg;

    // Register byte offsets (one aligned word each)
    localparam logic [5:0] OFS_MODEM_STATUS = 6'h00;
    localparam logic [5:0] OFS_SCRATCH = 6'h04;
    localparam logic [5:0] OFS_DIV_LOW = 6'h08;
    localparam logic [5:0] OFS_DIV_HIGH = 6'h0C;
    localparam logic [5:0] OFS_MODEM_CTRL = 6'h10;
    localparam logic [5:0] OFS_INT_ENABLE = 6'h14;
    localparam logic [5:0] OFS_EVT_STATUS = 6'h18;
    localparam logic [5:0] OFS_EVT_MASK = 6'h1C;
    localparam logic [5:0] OFS_CONFIG = 6'h20;

    // Modem status fields
    localparam int MS_DCTS = 0;
    localparam int MS_DDSR = 1;
    localparam int MS_TERI = 2;
    localparam int MS_DCD = 3;
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;
    localparam int MS_RI = 6;
    localparam int MS_CD = 7;

    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OP1 = 2;
    localparam int MC_OP2 = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_WIDTH = 5;

    // Interrupt enable field for modem status
    localparam int IE_MODEM = 3;

    // Event status / mask fields
    localparam int EV_MODEM = 0;
    localparam int EV_WIDTH = 1;

    // Config fields: bus mode and variant
    localparam int CF_BUS68 = 0;
    localparam int CF_VARIANT = 1;
    localparam int CF_WIDTH = 2;

    // Reset values
    localparam logic [7:0] SCRATCH_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] DELTA_ZERO = 4'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Transmit gating states
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_HOLD = 3'b100
    } tx_gate_e;

endpackage

// *** verilog/modem_status_block.sv ***
/*
 * Modem status tracking, transmit gating by clear-to-send, loopback
 * mapping, scratch storage, baud divisor pair and reset states for one
 * serial channel. Assumes modem inputs arrive from pins (synchronised
 * here), and a transmitter that pulses char_start/char_done.
 */
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Ring flag sets on ring input low to high
// - Carrier flag sets on any carrier input toggle
// - Change flag with enable bit requests interrupt
// - Clear-to-send high stops after current character
// - Status bit 4 inverts CTS, loopback RTS
// - Status bit 5 inverts DSR, loopback DTR
// - Status bit 6 inverts RI, loopback control bit 2
// - Status bit 7 inverts CD, loopback control bit 3
// - Eight-bit scratch register stores written value
// - Divisor is high byte over low byte
// - Divisor registers unaffected by reset
// - Reset clears flags, upper bits follow inputs
// - Interrupt tristate only in one mode configuration
// - CTS and DSR flags set on toggle
module modem_status_block
    import modem_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Modem pins, active low, and the active-high interrupt_output_select
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic ring_indicator_n,
    input wire logic carrier_detect_n,
    input wire logic interrupt_output_select,
    output logic request_to_send_n,
    output logic terminal_ready_n,
    // Transmitter handshake
    input wire logic char_start,
    input wire logic char_done,
    output logic tx_allow,
    output logic serial_tx_out,
    output logic infrared_transmit_out,
    output logic receive_ready_n,
    output logic transmit_ready_n,
    output logic [15:0] baud_divisor,
    // Interrupt pin as two signals, plus block level interrupt
    output logic channel_irq_out,
    output logic channel_irq_oe,
    output logic irq
);

    // Two-stage synchronisers for the four modem inputs
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [3:0] pin_prev_reg;    // Last level, for change detection
    logic int_sel_meta_reg;
    logic int_sel_reg;

    // Software visible state
    logic [7:0] scratch_reg;
    logic [7:0] div_low_reg;
    logic [7:0] div_high_reg;
    logic [MC_WIDTH-1:0] modem_ctrl_reg;
    logic [7:0] int_enable_reg;
    logic [3:0] delta_reg;
    logic [EV_WIDTH-1:0] evt_status_reg;
    logic [EV_WIDTH-1:0] evt_mask_reg;
    logic [CF_WIDTH-1:0] config_reg;
    logic [31:0] readdata_reg;
    logic primed_reg;            // Previous levels valid after reset
    logic rd_pending_reg;        // Read data captured, answer this cycle
    logic div_lo_seen_reg;       // Low divisor byte written since power-up
    logic div_hi_seen_reg;       // High divisor byte written since power-up

    // Derived status
    logic [3:0] status_hi;       // CTS, DSR, RI, CD in status order
    logic [3:0] sense_lvl;       // Levels seen by change detection
    logic [3:0] delta_set;
    logic [7:0] modem_status;
    logic rd_status;
    logic bus_wr;
    logic bus_rd;
    logic modem_req;
    tx_gate_e tx_state_reg;

    // Reads take one wait state so registered data stands at the answer
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_pending_reg <= 1'b0;
        end else begin
            rd_pending_reg <= read & ~rd_pending_reg;
        end
    end

    // Writes never stall; a read stalls only in its capture cycle
    assign waitrequest = read & ~rd_pending_reg;
    assign bus_wr = write & byteenable[0];
    assign bus_rd = read & ~rd_pending_reg;
    assign rd_status = bus_rd && (address == OFS_MODEM_STATUS);

    // Synchronise pins; order is CD, RI, DSR, CTS from msb
    always_ff @(posedge ref_clk) begin
        pin_meta_reg <= {carrier_detect_n, ring_indicator_n,
                         data_set_ready_n, clear_to_send_n};
        pin_sync_reg <= pin_meta_reg;
        int_sel_meta_reg <= interrupt_output_select;
        int_sel_reg <= int_sel_meta_reg;
    end

    // Upper status bits: inverted pins, or control bits in loopback
    always_comb begin
        if (modem_ctrl_reg[MC_LOOP]) begin
            status_hi[0] = modem_ctrl_reg[MC_RTS];
            status_hi[1] = modem_ctrl_reg[MC_DTR];
            status_hi[2] = modem_ctrl_reg[MC_OP1];
            status_hi[3] = modem_ctrl_reg[MC_OP2];
        end else begin
            status_hi = ~pin_sync_reg;
        end
    end

    // Detection works on the active-low view of whichever source is live
    assign sense_lvl = ~status_hi;
    assign modem_status = {status_hi, delta_reg};

    // Per-input change events
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_delta
            if (gi == MS_TERI) begin : g_ring
                // Only the end of ringing counts
                assign delta_set[gi] = primed_reg & sense_lvl[gi]
                                       & ~pin_prev_reg[gi];
            end else begin : g_toggle
                // Any edge since last read
                assign delta_set[gi] = primed_reg
                    & (sense_lvl[gi] ^ pin_prev_reg[gi]);
            end
        end
    endgenerate

    // Previous level tracking; first cycle after reset only primes
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_prev_reg <= DELTA_ZERO;
            primed_reg <= 1'b0;
        end else begin
            pin_prev_reg <= sense_lvl;
            primed_reg <= 1'b1;
        end
    end

    // Change flags: cleared by status read, new edge wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            delta_reg <= DELTA_ZERO;
        end else if (rd_status) begin
            delta_reg <= delta_set;
        end else begin
            delta_reg <= delta_reg | delta_set;
        end
    end

    // Modem interrupt request from any flag with enable bit
    assign modem_req = (|delta_reg) & int_enable_reg[IE_MODEM];

    // Scratch storage: plain store, no side effects
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scratch_reg <= SCRATCH_RESET;
        end else if (bus_wr && address == OFS_SCRATCH) begin
            scratch_reg <= writedata[7:0];
        end
    end

    // Divisor pair: no reset on purpose, power-up content undefined
    always_ff @(posedge ref_clk) begin
        if (bus_wr && address == OFS_DIV_LOW) begin
            div_low_reg <= writedata[7:0];
            div_lo_seen_reg <= 1'b1;
        end
        if (bus_wr && address == OFS_DIV_HIGH) begin
            div_high_reg <= writedata[7:0];
            div_hi_seen_reg <= 1'b1;
        end
    end

    // Divisor formed high byte then low byte
    always_ff @(posedge ref_clk) begin
        baud_divisor <= {div_high_reg, div_low_reg};
    end

    // Control registers with reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            modem_ctrl_reg <= BYTE_ZERO[MC_WIDTH-1:0];
            int_enable_reg <= BYTE_ZERO;
            evt_mask_reg <= BYTE_ZERO[EV_WIDTH-1:0];
            config_reg <= BYTE_ZERO[CF_WIDTH-1:0];
        end else if (bus_wr) begin
            if (address == OFS_MODEM_CTRL) begin
                modem_ctrl_reg <= writedata[MC_WIDTH-1:0];
            end else if (address == OFS_INT_ENABLE) begin
                int_enable_reg <= writedata[7:0];
            end else if (address == OFS_EVT_MASK) begin
                evt_mask_reg <= writedata[EV_WIDTH-1:0];
            end else if (address == OFS_CONFIG) begin
                config_reg <= writedata[CF_WIDTH-1:0];
            end
        end
    end

    // Sticky event: set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            evt_status_reg <= BYTE_ZERO[EV_WIDTH-1:0];
        end else begin
            for (int i = 0; i < EV_WIDTH; i++) begin
                if (i == EV_MODEM && modem_req) begin
                    evt_status_reg[i] <= 1'b1;
                end else if (bus_wr && address == OFS_EVT_STATUS
                             && writedata[i]) begin
                    evt_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(evt_status_reg & evt_mask_reg);

    // Read mux, registered; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            readdata_reg <= READ_ZERO;
        end else if (bus_rd) begin
            if (address == OFS_MODEM_STATUS) begin
                readdata_reg <= {24'h000000, modem_status};
            end else if (address == OFS_SCRATCH) begin
                readdata_reg <= {24'h000000, scratch_reg};
            end else if (address == OFS_DIV_LOW) begin
                readdata_reg <= {24'h000000, div_low_reg};
            end else if (address == OFS_DIV_HIGH) begin
                readdata_reg <= {24'h000000, div_high_reg};
            end else if (address == OFS_MODEM_CTRL) begin
                readdata_reg <= {27'h0000000, modem_ctrl_reg};
            end else if (address == OFS_INT_ENABLE) begin
                readdata_reg <= {24'h000000, int_enable_reg};
            end else if (address == OFS_EVT_STATUS) begin
                readdata_reg <= {31'h00000000, evt_status_reg};
            end else if (address == OFS_EVT_MASK) begin
                readdata_reg <= {31'h00000000, evt_mask_reg};
            end else if (address == OFS_CONFIG) begin
                readdata_reg <= {30'h00000000, config_reg};
            end else begin
                readdata_reg <= READ_ZERO;
            end
        end
    end

    // Data is captured in the wait cycle and stands at the answer edge
    always_comb begin
        readdata = readdata_reg;
    end

    // Transmit gating: finish the character in progress before holding
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_state_reg <= TX_IDLE;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (status_hi[0] == 1'b0) begin
                        tx_state_reg <= TX_HOLD;
                    end else if (char_start) begin
                        tx_state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (char_done) begin
                        tx_state_reg <= status_hi[0] ? TX_IDLE
                                                     : TX_HOLD;
                    end
                end
                TX_HOLD: begin
                    if (status_hi[0]) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // Start of a new character allowed only when not held
    assign tx_allow = (tx_state_reg == TX_IDLE) && status_hi[0];

    // Serial side pins: idle levels on reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            serial_tx_out <= 1'b1;
            infrared_transmit_out <= 1'b0;
            receive_ready_n <= 1'b1;
            transmit_ready_n <= 1'b0;
            request_to_send_n <= 1'b1;
            terminal_ready_n <= 1'b1;
        end else begin
            serial_tx_out <= 1'b1;
            infrared_transmit_out <= 1'b0;
            receive_ready_n <= 1'b1;
            transmit_ready_n <= 1'b0;
            // Loopback keeps the pins inactive
            request_to_send_n <= ~modem_ctrl_reg[MC_RTS]
                                 | modem_ctrl_reg[MC_LOOP];
            terminal_ready_n <= ~modem_ctrl_reg[MC_DTR]
                                | modem_ctrl_reg[MC_LOOP];
        end
    end

    // Channel interrupt pin: tristate only in one bus mode and variant
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            channel_irq_out <= 1'b0;
            channel_irq_oe <= 1'b0;
        end else begin
            channel_irq_out <= modem_req;
            if (config_reg[CF_BUS68] || config_reg[CF_VARIANT]
                || int_sel_reg) begin
                channel_irq_oe <= 1'b1;
            end else begin
                channel_irq_oe <= modem_ctrl_reg[MC_OP2];
            end
        end
    end

    // Flags clear after reset
    property p_reset_clears;
        @(posedge ref_clk) !rst_b |=> (delta_reg == DELTA_ZERO);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("change flags not cleared by reset");

    // Ring high to low of the active-low view never sets flag alone
    property p_ring_rise;
        @(posedge ref_clk) disable iff (!rst_b)
        (primed_reg && sense_lvl[MS_TERI] && !pin_prev_reg[MS_TERI])
        |=> delta_reg[MS_TERI];
    endproperty
    a_ring_rise: assert property (p_ring_rise)
        else $error("ring end did not set flag");

    property p_ring_fall;
        @(posedge ref_clk) disable iff (!rst_b)
        (!delta_reg[MS_TERI] && !delta_set[MS_TERI])
        |=> !delta_reg[MS_TERI];
    endproperty
    a_ring_fall: assert property (p_ring_fall)
        else $error("ring flag set without rising ring input");

    property p_cd_toggle;
        @(posedge ref_clk) disable iff (!rst_b)
        (primed_reg && $changed(sense_lvl[MS_DCD])) |=> delta_reg[MS_DCD];
    endproperty
    a_cd_toggle: assert property (p_cd_toggle)
        else $error("carrier toggle missed");

    property p_cts_toggle;
        @(posedge ref_clk) disable iff (!rst_b)
        (primed_reg && sense_lvl[MS_DCTS] != pin_prev_reg[MS_DCTS])
        |=> delta_reg[MS_DCTS];
    endproperty
    a_cts_toggle: assert property (p_cts_toggle)
        else $error("clear-to-send toggle missed");

    property p_irq_req;
        @(posedge ref_clk) disable iff (!rst_b)
        (|delta_reg && int_enable_reg[IE_MODEM])
        |=> evt_status_reg[EV_MODEM];
    endproperty
    a_irq_req: assert property (p_irq_req)
        else $error("modem interrupt not requested");

    property p_loop_map;
        @(posedge ref_clk) disable iff (!rst_b)
        modem_ctrl_reg[MC_LOOP] |-> (modem_status[MS_CTS]
            == modem_ctrl_reg[MC_RTS]) && (modem_status[MS_CD]
            == modem_ctrl_reg[MC_OP2]);
    endproperty
    a_loop_map: assert property (p_loop_map)
        else $error("loopback mapping wrong");

    property p_norm_map;
        @(posedge ref_clk) disable iff (!rst_b)
        !modem_ctrl_reg[MC_LOOP] |-> (modem_status[7:4] == ~pin_sync_reg);
    endproperty
    a_norm_map: assert property (p_norm_map)
        else $error("status bits not inverted inputs");

    sequence s_hold_req;
        tx_state_reg == TX_SEND && char_done && !status_hi[0];
    endsequence
    property p_tx_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        s_hold_req |=> !tx_allow;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmitter not held by clear-to-send");

    property p_div_keep;
        @(posedge ref_clk) (!rst_b && !bus_wr && div_lo_seen_reg
                            && div_hi_seen_reg)
        |=> $stable(div_low_reg) && $stable(div_high_reg);
    endproperty
    a_div_keep: assert property (p_div_keep)
        else $error("divisor changed by reset");

endmodule

// *** tb/modem_line_model.sv ***
/*
 * Behavioural model of the modem standing on the far side of the
 * channel's modem pins. Assumes the bench names, as plain asserted-high
 * levels, which of the four modem lines the modem currently asserts.
 */
`timescale 1ns/1ps

module modem_line_model (
    input wire logic [3:0] line_on,
    output logic clear_to_send_n,
    output logic data_set_ready_n,
    output logic ring_indicator_n,
    output logic carrier_detect_n
);
    // Pins are active low; an asserted line pulls its pin low
    assign clear_to_send_n = ~line_on[0];
    assign data_set_ready_n = ~line_on[1];
    // Ring ends when the pin returns high
    assign ring_indicator_n = ~line_on[2];
    assign carrier_detect_n = ~line_on[3];
endmodule

// *** tb/modem_status_block_tb_top.sv ***
/*
 * Self-checking bench for the modem status block: bus tasks, modem
 * traffic through the line model, interrupt, loopback and gating tests.
 * Assumes Avalon-MM timing: read data taken when waitrequest is low.
 */
`timescale 1ns/1ps

module modem_status_block_tb_top;
    import modem_status_pkg::*;
    logic ref_clk;
    logic rst_b;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [3:0] line_on; // Asserted modem lines: cd, ri, dsr, cts
    logic int_sel;
    logic char_start;
    logic char_done;
    logic cts_n, dsr_n, ri_n, cd_n;
    logic rts_n, dtr_n, tx_allow, tx_out, ir_out, rx_rdy_n, tx_rdy_n;
    logic irq_out, irq_oe, irq;
    logic [15:0] baud_divisor;
    logic [31:0] rd; // Last read data
    int miscompares;
    int num_checks;
    logic [3:0] lv [6] = '{4'h0, 4'h2, 4'h6, 4'h2, 4'hA, 4'h2};
    logic [3:0] ef [6] = '{4'h1, 4'h2, 4'h0, 4'h4, 4'h8, 4'h8};
    logic [7:0] lb [4] = '{8'h12, 8'h11, 8'h14, 8'h18};

    modem_line_model modem_line_model_i (.line_on(line_on),
        .clear_to_send_n(cts_n), .data_set_ready_n(dsr_n),
        .ring_indicator_n(ri_n), .carrier_detect_n(cd_n));

    modem_status_block modem_status_block_i (.ref_clk(ref_clk),
        .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .clear_to_send_n(cts_n),
        .data_set_ready_n(dsr_n), .ring_indicator_n(ri_n),
        .carrier_detect_n(cd_n), .interrupt_output_select(int_sel),
        .request_to_send_n(rts_n), .terminal_ready_n(dtr_n),
        .char_start(char_start), .char_done(char_done),
        .tx_allow(tx_allow), .serial_tx_out(tx_out),
        .infrared_transmit_out(ir_out), .receive_ready_n(rx_rdy_n),
        .transmit_ready_n(tx_rdy_n), .baud_divisor(baud_divisor),
        .channel_irq_out(irq_out), .channel_irq_oe(irq_oe), .irq(irq));

    // Free-running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // One comparison, counted; four-state equality so X never matches
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus write; one idle edge after release so calls never collide
    task automatic bus_write(input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Bus read; data taken at the edge where waitrequest is low
    task automatic bus_read(input logic [5:0] a);
        address <= a;
        read <= 1'b1;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        rd = readdata;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Bounded wait for a level; the poll is cut short, never endless
    task automatic wait_level(ref logic sig, input logic lvl);
        for (int k = 0; k < 20 && sig !== lvl; k++) @(posedge ref_clk);
    endtask

    // Change modem lines, poll status, check flags, then flags cleared
    task automatic modem_step(input logic [3:0] v, input logic [3:0] e);
        logic [3:0] seen;
        seen = 4'h0;
        line_on <= v;
        @(posedge ref_clk);
        for (int k = 0; k < 8 && seen == 4'h0; k++) begin
            bus_read(OFS_MODEM_STATUS);
            seen = rd[3:0];
        end
        check("change flags", {28'h0, e}, {28'h0, seen});
        bus_read(OFS_MODEM_STATUS);
        check("status levels", {28'h0, v}, {28'h0, rd[7:4]});
        check("flags after read", 32'h0, {28'h0, rd[3:0]});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog: the whole run needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test;
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        line_on = 4'h1;
        int_sel = 1'b0;
        char_start = 1'b0;
        char_done = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // Reset levels of pins and registers
        check("tx idle", 32'h1, {31'h0, tx_out});
        check("ir tx", 32'h0, {31'h0, ir_out});
        check("rts pin", 32'h1, {31'h0, rts_n});
        check("dtr pin", 32'h1, {31'h0, dtr_n});
        check("rx ready", 32'h1, {31'h0, rx_rdy_n});
        check("tx ready", 32'h0, {31'h0, tx_rdy_n});
        check("irq enable", 32'h0, {31'h0, irq_oe});
        bus_read(OFS_MODEM_STATUS);
        check("status reset", 32'h10, rd);
        bus_read(OFS_SCRATCH);
        check("scratch reset", 32'hFF, rd);
        $display("test reset done");
        // Scratch storage and an unmapped place
        foreach (lb[i]) begin
            bus_write(OFS_SCRATCH, {24'h0, ~lb[i]});
            bus_read(OFS_SCRATCH);
            check("scratch", {24'h0, ~lb[i]}, rd);
        end
        bus_read(6'h3C);
        check("unmapped", 32'h0, rd);
        // Divisor pair, kept through a reset pulse
        bus_write(OFS_DIV_LOW, 32'h34);
        bus_write(OFS_DIV_HIGH, 32'h12);
        @(posedge ref_clk);
        check("divisor", 32'h1234, {16'h0, baud_divisor});
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        bus_read(OFS_DIV_HIGH);
        check("divisor high kept", 32'h12, rd);
        check("divisor kept", 32'h1234, {16'h0, baud_divisor});
        $display("test registers done");
        // Modem line changes and their flags
        foreach (lv[i]) modem_step(lv[i], ef[i]);
        $display("test change flags done");
        // Modem interrupt: raise, mask, clear
        bus_write(OFS_INT_ENABLE, 32'h08);
        bus_write(OFS_EVT_MASK, 32'h1);
        line_on <= 4'h3;
        wait_level(irq, 1'b1);
        check("irq raised", 32'h1, {31'h0, irq});
        check("modem request", 32'h1, {31'h0, irq_out});
        bus_write(OFS_EVT_MASK, 32'h0);
        check("irq masked", 32'h0, {31'h0, irq});
        bus_read(OFS_EVT_STATUS);
        check("event status", 32'h1, rd);
        bus_read(OFS_MODEM_STATUS);
        bus_write(OFS_INT_ENABLE, 32'h0);
        bus_write(OFS_EVT_STATUS, 32'h1);
        bus_write(OFS_EVT_MASK, 32'h1);
        check("irq cleared", 32'h0, {31'h0, irq});
        check("request cleared", 32'h0, {31'h0, irq_out});
        $display("test interrupt done");
        // Loopback mapping of the upper status bits
        bus_write(OFS_MODEM_CTRL, 32'h1F);
        bus_read(OFS_MODEM_STATUS);
        check("loop all", 32'hF, {28'h0, rd[7:4]});
        check("loop rts pin", 32'h1, {31'h0, rts_n});
        foreach (lb[i]) begin
            bus_write(OFS_MODEM_CTRL, {24'h0, lb[i]});
            bus_read(OFS_MODEM_STATUS);
            check("loop bit", 32'h1 << i, {28'h0, rd[7:4]});
        end
        bus_write(OFS_MODEM_CTRL, 32'h0B);
        bus_read(OFS_MODEM_STATUS);
        check("rts pin", 32'h0, {31'h0, rts_n});
        check("dtr pin", 32'h0, {31'h0, dtr_n});
        check("irq drive ctrl", 32'h1, {31'h0, irq_oe});
        bus_write(OFS_MODEM_CTRL, 32'h0);
        @(posedge ref_clk);
        check("irq tristate", 32'h0, {31'h0, irq_oe});
        int_sel <= 1'b1;
        wait_level(irq_oe, 1'b1);
        check("irq drive sel", 32'h1, {31'h0, irq_oe});
        int_sel <= 1'b0;
        wait_level(irq_oe, 1'b0);
        check("irq tristate sel", 32'h0, {31'h0, irq_oe});
        bus_write(OFS_CONFIG, 32'h1);
        @(posedge ref_clk);
        check("irq drive mode", 32'h1, {31'h0, irq_oe});
        bus_write(OFS_CONFIG, 32'h0);
        bus_read(OFS_MODEM_STATUS);
        $display("test loopback done");
        // Clear-to-send gating around a character in flight
        wait_level(tx_allow, 1'b1);
        check("tx allowed", 32'h1, {31'h0, tx_allow});
        char_start <= 1'b1;
        @(posedge ref_clk);
        char_start <= 1'b0;
        line_on <= 4'h2;
        repeat (8) @(posedge ref_clk);
        char_done <= 1'b1;
        @(posedge ref_clk);
        char_done <= 1'b0;
        wait_level(tx_allow, 1'b0);
        check("tx held", 32'h0, {31'h0, tx_allow});
        line_on <= 4'h3;
        wait_level(tx_allow, 1'b1);
        check("tx resumed", 32'h1, {31'h0, tx_allow});
        $display("test gating done");
        finish_test;
    end
endmodule
